// File: pkg/cbb_pkg.sv
package cbb_pkg;

  localparam int CBB_ADDR_W = 16;
  localparam int CBB_DATA_W = 16;
  localparam int CBB_BYTE_W = 8;
  localparam int CBB_SEG_W = 7;
  localparam int CBB_STAT_W = 4;

  // Status code driven while no transaction is in progress (internal operation).
  localparam logic [CBB_STAT_W-1:0] CBB_STATUS_IDLE = 4'h0;
  localparam logic [CBB_SEG_W-1:0] CBB_SEG_RST = 7'h00;
  localparam logic [CBB_DATA_W-1:0] CBB_BUS_RST = 16'h0000;
  localparam logic [CBB_BYTE_W-1:0] CBB_BYTE_ZERO = 8'h00;

  // Upper half of the bus carries the even byte, lower half the odd byte.
  localparam int CBB_EVEN_LSB = 8;
  localparam int CBB_ODD_LSB = 0;

  // One transaction request from the user side.
  typedef struct packed {
    logic [CBB_SEG_W-1:0] seg;
    logic [CBB_STAT_W-1:0] status;
    logic [CBB_ADDR_W-1:0] addr;
    logic [CBB_DATA_W-1:0] wdata;
    logic write;
    logic byte_mode;
  } cbb_req_t;

  // Read answer to the user side.
  typedef struct packed {
    logic valid;
    logic [CBB_DATA_W-1:0] data;
  } cbb_resp_t;

  typedef enum logic [5:0] {
    CBB_ST_IDLE = 6'b000001,
    CBB_ST_SEG = 6'b000010,
    CBB_ST_T1 = 6'b000100,
    CBB_ST_T2 = 6'b001000,
    CBB_ST_TW = 6'b010000,
    CBB_ST_T3 = 6'b100000
  } cbb_state_t;

endpackage

// File: verilog/cbb_byte_steer.sv
`timescale 1ns/1ps
module cbb_byte_steer #(
  parameter int DATA_W = 16,
  parameter int BYTE_W = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic cap_valid,
  input wire logic byte_mode,
  input wire logic addr_lsb,
  input wire logic [DATA_W-1:0] word,
  output cbb_pkg::cbb_resp_t resp
);
  import cbb_pkg::*;

  if (DATA_W != 2 * BYTE_W || DATA_W != CBB_DATA_W) begin : g_chk
    $error("cbb_byte_steer: bus must be two bytes of the package width");
  end

  logic [DATA_W-1:0] data_d;

  // The memory always returns a whole word; the byte is chosen here.
  always_comb begin
    data_d = word;
    if (byte_mode) begin
      if (addr_lsb) begin
        data_d = {CBB_BYTE_ZERO, word[CBB_ODD_LSB +: BYTE_W]};
      end else begin
        data_d = {CBB_BYTE_ZERO, word[CBB_EVEN_LSB +: BYTE_W]};
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      resp <= '0;
    end else begin
      resp.valid <= cap_valid;
      if (cap_valid) begin
        resp.data <= data_d;
      end
    end
  end

  a_byte_pick: assert property (@(posedge clk_sys) disable iff (rst)
    cap_valid && byte_mode |=> resp.data == {CBB_BYTE_ZERO,
      (($past(addr_lsb)) ? $past(word[7:0]) : $past(word[15:8]))})
    else $error("byte read picked the wrong half of the bus");

endmodule

// File: verilog/cbb_bus_master.sv
`timescale 1ns/1ps
// Contract
// - Byte read takes even upper, odd lower half.
// - Byte write duplicates byte on both halves.
// - Status held whole transaction; address withdrawn early.
// - Segment number valid cycle before transaction.
// - Read turns bus around, marked by data strobe.
// - Write replaces address with data, no turnaround.
// - Wait input sampled where flag is cleared.
// - Word transactions hold byte/word low.
module cbb_bus_master (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic req_valid,
  input cbb_pkg::cbb_req_t req,
  output logic req_ready,
  output cbb_pkg::cbb_resp_t resp,
  output logic address_strobe_n,
  output logic data_strobe_n,
  output logic memory_request_n,
  output logic read_write,
  output logic byte_word,
  output logic [cbb_pkg::CBB_STAT_W-1:0] transaction_status,
  output logic [cbb_pkg::CBB_SEG_W-1:0] segment_number,
  output logic [cbb_pkg::CBB_DATA_W-1:0] mux_addr_data_bus_out,
  output logic mux_addr_data_bus_oe,
  input wire logic [cbb_pkg::CBB_DATA_W-1:0] mux_addr_data_bus_in,
  input wire logic wait_n
);
  import cbb_pkg::*;

  cbb_state_t state_q;
  cbb_state_t state_d;
  cbb_req_t req_q;
  cbb_req_t req_d;
  logic wait_q;
  logic [CBB_DATA_W-1:0] bus_s1_q;
  logic [CBB_DATA_W-1:0] bus_s2_q;
  logic cap_q;
  logic active_d;
  logic drive_data_d;
  logic [CBB_DATA_W-1:0] wdata_bus;

  // The data pins come from outside the clock domain, so two flops each.
  // The wait flag runs on the inverted system clock, so it is of this domain and one
  // register suffices; a second one would push a one-wait request past the data cycle.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wait_q <= 1'b1;
      bus_s1_q <= CBB_BUS_RST;
      bus_s2_q <= CBB_BUS_RST;
    end else begin
      wait_q <= wait_n;
      bus_s1_q <= mux_addr_data_bus_in;
      bus_s2_q <= bus_s1_q;
    end
  end

  always_comb begin
    state_d = state_q;
    req_d = req_q;
    unique case (state_q)
      CBB_ST_IDLE: begin
        if (req_valid) begin
          state_d = CBB_ST_SEG;
          req_d = req;
        end
      end
      CBB_ST_SEG: state_d = CBB_ST_T1;
      CBB_ST_T1: state_d = CBB_ST_T2;
      CBB_ST_T2: begin
        // The level registered at the end of the address cycle decides the first wait.
        state_d = wait_q ? CBB_ST_T3 : CBB_ST_TW;
      end
      CBB_ST_TW: begin
        state_d = wait_q ? CBB_ST_T3 : CBB_ST_TW;
      end
      CBB_ST_T3: state_d = CBB_ST_IDLE;
      default: state_d = CBB_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= CBB_ST_IDLE;
      req_q <= '0;
    end else begin
      state_q <= state_d;
      req_q <= req_d;
    end
  end

  assign active_d = (state_d != CBB_ST_IDLE);
  assign drive_data_d = req_d.write &&
    (state_d == CBB_ST_T2 || state_d == CBB_ST_TW || state_d == CBB_ST_T3);
  // A byte write sends the low byte of the source on both halves.
  assign wdata_bus = req_d.byte_mode ?
    {req_d.wdata[CBB_BYTE_W-1:0], req_d.wdata[CBB_BYTE_W-1:0]} : req_d.wdata;

  // Strobes.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      address_strobe_n <= 1'b1;
      data_strobe_n <= 1'b1;
      memory_request_n <= 1'b1;
      req_ready <= 1'b0;
    end else begin
      address_strobe_n <= (state_d != CBB_ST_T1);
      data_strobe_n <= !(state_d == CBB_ST_T2 || state_d == CBB_ST_TW);
      memory_request_n <= !(active_d && state_d != CBB_ST_SEG);
      req_ready <= (state_d == CBB_ST_IDLE);
    end
  end

  // Transaction attributes stand from the segment cycle to the end.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      transaction_status <= CBB_STATUS_IDLE;
      segment_number <= CBB_SEG_RST;
      read_write <= 1'b1;
      byte_word <= 1'b0;
    end else begin
      transaction_status <= active_d ? req_d.status : CBB_STATUS_IDLE;
      segment_number <= active_d ? req_d.seg : CBB_SEG_RST;
      read_write <= active_d ? !req_d.write : 1'b1;
      byte_word <= active_d && req_d.byte_mode;
    end
  end

  // Address in the address cycle only; write data replaces it, reads release the bus.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mux_addr_data_bus_out <= CBB_BUS_RST;
      mux_addr_data_bus_oe <= 1'b0;
    end else begin
      if (state_d == CBB_ST_T1) begin
        mux_addr_data_bus_out <= req_d.addr;
        mux_addr_data_bus_oe <= 1'b1;
      end else if (drive_data_d) begin
        mux_addr_data_bus_out <= wdata_bus;
        mux_addr_data_bus_oe <= 1'b1;
      end else begin
        mux_addr_data_bus_out <= CBB_BUS_RST;
        mux_addr_data_bus_oe <= 1'b0;
      end
    end
  end

  // Read data sampled while the strobe was low reaches the second flop one cycle after T3.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cap_q <= 1'b0;
    end else begin
      cap_q <= (state_q == CBB_ST_T3) && !req_q.write;
    end
  end

  cbb_byte_steer #(
    .DATA_W(CBB_DATA_W),
    .BYTE_W(CBB_BYTE_W)
  ) u_steer (
    .clk_sys(clk_sys),
    .rst(rst),
    .cap_valid(cap_q),
    .byte_mode(req_q.byte_mode),
    .addr_lsb(req_q.addr[0]),
    .word(bus_s2_q),
    .resp(resp)
  );

  a_seg_lead: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(address_strobe_n) |-> $stable(segment_number) && segment_number == req_q.seg)
    else $error("segment number not valid before the address strobe");

  a_status_hold: assert property (@(posedge clk_sys) disable iff (rst)
    !memory_request_n && !$fell(memory_request_n) |->
      $stable(transaction_status) && $stable(read_write) && $stable(byte_word))
    else $error("transaction attributes changed mid transaction");

  a_addr_release: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(address_strobe_n) && read_write |-> !mux_addr_data_bus_oe ##1 !mux_addr_data_bus_oe)
    else $error("address still driven after the address strobe on a read");

  a_read_turn: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(address_strobe_n) |-> !data_strobe_n and (read_write |-> !mux_addr_data_bus_oe))
    else $error("read turnaround not marked by the data strobe");

  a_byte_dup: assert property (@(posedge clk_sys) disable iff (rst)
    !data_strobe_n && !read_write && byte_word |->
      mux_addr_data_bus_out[15:8] == mux_addr_data_bus_out[7:0])
    else $error("byte write not duplicated on both halves");

  a_write_drive: assert property (@(posedge clk_sys) disable iff (rst)
    !read_write && !memory_request_n |-> mux_addr_data_bus_oe)
    else $error("bus released during a write");

  a_wait_hold: assert property (@(posedge clk_sys) disable iff (rst)
    state_q == CBB_ST_T2 && !wait_q |=> !data_strobe_n && state_q == CBB_ST_TW)
    else $error("wait request not honoured");

  a_wait_skip: assert property (@(posedge clk_sys) disable iff (rst)
    state_q == CBB_ST_T2 && wait_q |=> data_strobe_n && state_q == CBB_ST_T3)
    else $error("wait cycle inserted without a wait request");

  a_word_low: assert property (@(posedge clk_sys) disable iff (rst)
    !data_strobe_n && !req_q.byte_mode |-> !byte_word)
    else $error("byte/word high during a word transaction");

endmodule

// File: tb/cbb_mem_model.sv
`timescale 1ns/1ps
module cbb_mem_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic wait_en,
  input wire logic address_strobe_n,
  input wire logic data_strobe_n,
  input wire logic memory_request_n,
  input wire logic read_write,
  input wire logic byte_word,
  input wire logic [cbb_pkg::CBB_DATA_W-1:0] mux_addr_data_bus_out,
  output logic [cbb_pkg::CBB_DATA_W-1:0] mux_addr_data_bus_in,
  output logic wait_n
);
  import cbb_pkg::*;
  logic [7:0] even_bank [0:8191];
  logic [7:0] odd_bank [0:8191];
  logic [15:0] addr_q;
  logic [15:0] last_q;
  logic hold_q;
  logic flag_q;
  logic [15:0] row_addr;
  logic board_enable;
  logic high_byte_write_n;
  logic low_byte_write_n;
  logic even_bank_write_sel;
  logic odd_bank_write_sel;

  initial begin
    for (int i = 0; i < 8192; i++) begin
      even_bank[i] = CBB_BYTE_ZERO;
      odd_bank[i] = CBB_BYTE_ZERO;
    end
  end

  // Sampling while the strobe is low gives the value present at its rising edge.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      addr_q <= CBB_BUS_RST;
    end else if (!address_strobe_n) begin
      addr_q <= mux_addr_data_bus_out;
    end
  end

  assign row_addr = address_strobe_n ? addr_q : mux_addr_data_bus_out;
  assign board_enable = !memory_request_n && row_addr[15:14] == 2'h0;
  assign high_byte_write_n = byte_word & addr_q[0];
  assign low_byte_write_n = byte_word & ~addr_q[0];
  assign even_bank_write_sel = !read_write && !high_byte_write_n;
  assign odd_bank_write_sel = !read_write && !low_byte_write_n;

  // The select is the data strobe, always inside the write enable window.
  always @(posedge clk_sys) begin
    if (!rst && board_enable && !data_strobe_n) begin
      if (even_bank_write_sel) begin
        even_bank[addr_q[13:1]] <= mux_addr_data_bus_out[15:8];
      end
      if (odd_bank_write_sel) begin
        odd_bank[addr_q[13:1]] <= mux_addr_data_bus_out[7:0];
      end
    end
  end

  // Data is held one cycle past the strobe for the capture hold, then the lines float and wander.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hold_q <= 1'h0;
      last_q <= 16'h5a5a;
    end else begin
      hold_q <= !data_strobe_n && read_write;
      last_q <= mux_addr_data_bus_in;
    end
  end

  assign mux_addr_data_bus_in = (board_enable && read_write && (!data_strobe_n || hold_q)) ?
    {even_bank[addr_q[13:1]], odd_bank[addr_q[13:1]]} : ~last_q;

  always_ff @(negedge clk_sys or posedge rst) begin
    if (rst) begin
      flag_q <= 1'h1;
    end else begin
      flag_q <= address_strobe_n;
    end
  end

  assign wait_n = flag_q || !(wait_en && board_enable);
endmodule

// File: tb/cpu_byte_bank_memory_interface_test.sv
`timescale 1ns/1ps
module cpu_byte_bank_memory_interface_test;
  import cbb_pkg::*;
  logic clk_sys, rst, req_valid, req_ready, wait_en, wait_n;
  logic address_strobe_n, data_strobe_n, memory_request_n, read_write, byte_word;
  logic [15:0] mux_addr_data_bus_out, mux_addr_data_bus_in;
  logic [3:0] transaction_status;
  logic [6:0] segment_number;
  logic mux_addr_data_bus_oe;
  cbb_req_t req;
  cbb_resp_t resp;
  logic [7:0] shadow [0:16383];
  int num_errors = 0;
  int n_tests = 0;

  initial begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end

  cbb_bus_master u_cbb_bus_master (.clk_sys, .rst, .req_valid, .req, .req_ready, .resp, .address_strobe_n,
    .data_strobe_n, .memory_request_n, .read_write, .byte_word, .transaction_status, .segment_number,
    .mux_addr_data_bus_out, .mux_addr_data_bus_oe, .mux_addr_data_bus_in, .wait_n);
  cbb_mem_model u_cbb_mem_model (.clk_sys, .rst, .wait_en, .address_strobe_n, .data_strobe_n,
    .memory_request_n, .read_write, .byte_word, .mux_addr_data_bus_out, .mux_addr_data_bus_in, .wait_n);

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [15:0] expect_read(input logic bm, input logic [15:0] a);
    return bm ? {8'h00, shadow[a[13:0]]} : {shadow[{a[13:1], 1'h0}], shadow[{a[13:1], 1'h1}]};
  endfunction

  // Entered just after an edge with the block idle; a wait only counts when the board is addressed.
  task automatic do_op(input logic wr, input logic bm, input logic [15:0] a, input logic [15:0] d,
                       input logic we);
    int k;
    logic on;
    on = a[15:14] == 2'h0;
    req.seg = 7'($urandom);
    req.status = 4'h8 | 4'($urandom);
    req.addr = a;
    req.wdata = d;
    req.write = wr;
    req.byte_mode = bm;
    wait_en = we;
    req_valid = 1'h1;
    @(posedge clk_sys);
    #1;
    req_valid = 1'h0;
    check("status", 16'(transaction_status), 16'(req.status));
    check("segment", 16'(segment_number), 16'(req.seg));
    check("bus enable in segment cycle", 16'(mux_addr_data_bus_oe), 16'h0000);
    k = 1;
    while ((wr ? req_ready : resp.valid) !== 1'h1) begin
      @(posedge clk_sys);
      #1;
      k++;
      if (k > 20) begin
        num_errors++;
        tally_and_finish();
      end
    end
    check("latency", 16'(k), 16'(wr ? 5 : 6) + 16'(we && on));
    check("idle status", 16'(transaction_status), 16'(CBB_STATUS_IDLE));
    check("idle bus enable", 16'(mux_addr_data_bus_oe), 16'h0000);
    if (!wr) begin
      check("read data", resp.data, expect_read(bm, a));
    end else if (on && bm) begin
      shadow[a[13:0]] = d[7:0];
    end else if (on) begin
      shadow[{a[13:1], 1'h0}] = d[15:8];
      shadow[{a[13:1], 1'h1}] = d[7:0];
    end
  endtask

  initial begin
    logic wr, bm;
    logic [15:0] a;
    rst = 1'h1;
    req_valid = 1'h0;
    req = '0;
    wait_en = 1'h0;
    void'($urandom(32'h92620346));
    for (int i = 0; i < 16384; i++) begin
      shadow[i] = 8'h00;
    end
    repeat (5) @(posedge clk_sys);
    #1;
    rst = 1'h0;
    @(posedge clk_sys);
    #1;
    do_op(1'h1, 1'h1, 16'h0101, 16'h00a5, 1'h0);
    do_op(1'h1, 1'h1, 16'h0100, 16'h003c, 1'h1);
    do_op(1'h0, 1'h0, 16'h0100, 16'h0000, 1'h0);
    do_op(1'h0, 1'h1, 16'h0101, 16'h0000, 1'h1);
    do_op(1'h1, 1'h0, 16'h3ffe, 16'hbeef, 1'h1);
    do_op(1'h1, 1'h0, 16'hbffe, 16'h1234, 1'h1);
    do_op(1'h0, 1'h1, 16'h3ffe, 16'h0000, 1'h0);
    do_op(1'h0, 1'h0, 16'h3ffe, 16'h0000, 1'h1);
    for (int i = 0; i < 200; i++) begin
      wr = 1'($urandom);
      bm = 1'($urandom);
      a = 16'($urandom);
      a[0] = a[0] & bm;
      if (!wr) begin
        a[15:14] = 2'h0;
      end
      do_op(wr, bm, a, 16'($urandom), 1'($urandom));
    end
    tally_and_finish();
  end
endmodule
